// >>> ucnt_pkg.sv
// Constants, register map and carrier types of the up/down event counter.
// Assumes a 32-bit APB slave port and a single 200 MHz clock.
package ucnt_pkg;

  localparam int COUNT_W = 32;
  localparam int STAMP_W = 64;
  localparam int ADDR_W = 8;
  localparam int CLK_PERIOD_NS = 5;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRESET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SNAP = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SNAP_TLO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SNAP_THI = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h24;

  localparam int CTRL_EN_BIT = 0;
  localparam int STATE_EN_BIT = 3;
  localparam int STATE_PRESET_BIT = 4;
  localparam int STATE_BLOCK_BIT = 5;
  localparam int INT_W = 3;
  localparam int INT_SNAP_BIT = 0;
  localparam int INT_WRAP_BIT = 1;
  localparam int INT_EQUAL_BIT = 2;

  localparam logic [COUNT_W-1:0] COUNT_MAX = 32'h7FFFFFFF;
  localparam logic [COUNT_W-1:0] COUNT_MIN = 32'h80000000;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h00000000;
  localparam logic [COUNT_W-1:0] PRESET_RST = 32'h00000000;
  localparam logic [COUNT_W-1:0] COMPARE_RST = 32'h00000000;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

  // Logic operands driven by the protection logic engine
  typedef struct packed {
    logic up;
    logic down;
    logic block;
    logic loadPresetSelect;
    logic rst;
    logic snapClear;
    logic snapKeep;
  } ucnt_in_t;

  localparam int IN_W = $bits(ucnt_in_t);

  typedef struct packed {
    logic aboveCompareFlag;
    logic equalCompareFlag;
    logic belowCompareFlag;
  } ucnt_flags_t;

  localparam ucnt_flags_t FLAGS_OFF = 3'h0;

endpackage

// >>> ucnt_edge.sv
// Per-bit rising-edge detector sampled once per logic evaluation pass.
// Assumes levels are synchronous to mclk and sample is a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none
module ucnt_edge #(
  parameter int W = 7
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic sample,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] prevLevel;
  logic [W-1:0] next_prevLevel;

  if (W < 1) begin : g_chk
    $error("ucnt_edge: W must be at least 1");
  end

  // Each bit is compared with its own level at the previous pass only
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign rise[i] = sample & level[i] & ~prevLevel[i]; // [RULE13]
    always_comb begin
      next_prevLevel[i] = sample ? level[i] : prevLevel[i];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prevLevel <= '0;
    end else if (ce) begin
      prevLevel <= next_prevLevel;
    end
  end

endmodule
`default_nettype wire

// >>> ucnt_counter.sv
// Signed 32-bit up/down event counter with compare flags, snapshots,
// APB register access, masked interrupt and power-fail save port.
// Assumes logic operands are synchronous to mclk; powerFail is a pin.
//
// Summary of operation
// [RULE1] Each low-to-high edge of the up operand adds one to the count.
// [RULE2] Incrementing the largest positive count wraps to the most negative.
// [RULE3] Down operand edges decrement; most negative wraps to largest positive.
// [RULE4] Count is compared with the compare value: above, equal, below flags.
// [RULE5] While block is high counting stops and all flags are inactive.
// [RULE6] On enabling, count loads preset if preset select high, else zero.
// [RULE7] While running, preset select rising edge loads the preset value.
// [RULE8] Reset or snapshot-and-clear loads preset if select high, else zero.
// [RULE9] The reset operand loads zero or preset per preset select level.
// [RULE10] Snapshot-and-clear stores count with time stamp, then clears count.
// [RULE11] Snapshot-and-keep stores count with time stamp, counting continues.
// [RULE12] On power loss, running count and snapshot are handed to storage.
// [RULE13] Edges are found against the previous pass: one step per pass.
`timescale 1ns/100ps
`default_nettype none
module ucnt_counter #(
  parameter int COUNT_BITS = ucnt_pkg::COUNT_W
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ucnt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic passTick,
  input wire ucnt_pkg::ucnt_in_t operands,
  input wire logic [ucnt_pkg::STAMP_W-1:0] dateTime,
  input wire logic powerFail,
  output ucnt_pkg::ucnt_flags_t flags,
  output logic irq,
  output logic nvSave,
  output logic [ucnt_pkg::COUNT_W-1:0] nvCount,
  output logic [ucnt_pkg::COUNT_W-1:0] nvSnap
);
  import ucnt_pkg::*;

  if (COUNT_BITS != COUNT_W) begin : g_chk
    $error("ucnt_counter: only a 32-bit count is supported");
  end

  // Stamp halves and status bits are read back as fixed word slices
  if (STAMP_W != 64) begin : g_chk_stamp
    $error("ucnt_counter: the time stamp must be 64 bits");
  end
  if (INT_W < 3 || INT_W > 32) begin : g_chk_int
    $error("ucnt_counter: status field must hold 3 to 32 bits");
  end
  if (ADDR_W < 6) begin : g_chk_addr
    $error("ucnt_counter: address too narrow for the register map");
  end

  // Register state
  logic ctrlEnable, next_ctrlEnable;
  logic [COUNT_W-1:0] presetVal, next_presetVal;
  logic [COUNT_W-1:0] compareVal, next_compareVal;
  logic [INT_W-1:0] intStat, next_intStat;
  logic [INT_W-1:0] intMask, next_intMask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;

  // Counter state
  logic [COUNT_W-1:0] count, next_count;
  logic [COUNT_W-1:0] snapVal, next_snapVal;
  logic [STAMP_W-1:0] snapTime, next_snapTime;
  logic enPrev, next_enPrev;
  ucnt_flags_t next_flags;
  logic wrapEvt, snapEvt, equalEvt;

  // Power-fail synchroniser and save port
  logic pfMeta, pfSync, pfPrev;
  logic next_nvSave;
  logic [COUNT_W-1:0] next_nvCount, next_nvSnap;

  ucnt_in_t rise;
  logic [IN_W-1:0] riseBits;
  logic apbDone, apbWr;
  logic [INT_W-1:0] clrBits;

  // Operands share mclk with this block, so no synchroniser sits here
  ucnt_edge #(
    .W(IN_W)
  ) u_edge (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .sample(passTick),
    .level(operands),
    .rise(riseBits)
  );
  assign rise = riseBits;

  // The write lands at the edge where the master sees pready high
  assign apbDone = psel & penable & pready;
  assign apbWr = apbDone & pwrite;

  // One clear strobe per status bit, raised by a written one
  for (genvar b = 0; b < INT_W; b++) begin : g_clr
    assign clrBits[b] = apbWr & (paddr == OFS_INT_STAT) & pwdata[b];
  end

  // Counter evaluation, once per logic pass
  always_comb begin
    logic [COUNT_W-1:0] loadVal;
    logic enRise;
    loadVal = operands.loadPresetSelect ? presetVal : COUNT_ZERO;
    enRise = ctrlEnable & ~enPrev;
    next_count = count;
    next_snapVal = snapVal;
    next_snapTime = snapTime;
    next_enPrev = enPrev;
    wrapEvt = 1'b0;
    snapEvt = 1'b0;
    if (passTick) begin
      next_enPrev = ctrlEnable;
      if (ctrlEnable) begin
        if (rise.snapClear || rise.snapKeep) begin
          // Snapshot takes the count as it stood before this pass
          next_snapVal = count; // [RULE10] [RULE11]
          next_snapTime = dateTime; // [RULE10] [RULE11]
          snapEvt = 1'b1;
        end
        if (enRise) begin
          next_count = loadVal; // [RULE6]
        end else if (operands.rst || rise.snapClear) begin
          next_count = loadVal; // [RULE8] [RULE9] [RULE10]
        end else if (rise.loadPresetSelect) begin
          next_count = presetVal; // [RULE7]
        end else if (!operands.block) begin // [RULE5]
          // Up and down in the same pass cancel; wrap is plain 2s-complement
          if (rise.up && !rise.down) begin
            next_count = count + 32'h00000001; // [RULE1] [RULE2]
            wrapEvt = (count == COUNT_MAX); // [RULE2]
          end else if (rise.down && !rise.up) begin
            next_count = count - 32'h00000001; // [RULE3]
            wrapEvt = (count == COUNT_MIN); // [RULE3]
          end
        end
      end
    end
  end

  // Compare flags follow the count continuously
  always_comb begin
    next_flags = FLAGS_OFF;
    if (ctrlEnable && !operands.block) begin // [RULE5]
      next_flags.aboveCompareFlag =
        ($signed(count) > $signed(compareVal)); // [RULE4]
      next_flags.equalCompareFlag = (count == compareVal); // [RULE4]
      next_flags.belowCompareFlag =
        ($signed(count) < $signed(compareVal)); // [RULE4]
    end
    equalEvt = next_flags.equalCompareFlag & ~flags.equalCompareFlag;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= COUNT_ZERO;
      snapVal <= COUNT_ZERO;
      snapTime <= '0;
      enPrev <= 1'b0;
      flags <= FLAGS_OFF;
    end else if (ce) begin
      count <= next_count;
      snapVal <= next_snapVal;
      snapTime <= next_snapTime;
      enPrev <= next_enPrev;
      flags <= next_flags;
    end
  end

  // Save the values on the first cycle the supply is seen failing
  always_comb begin
    next_nvSave = pfSync & ~pfPrev;
    next_nvCount = nvCount;
    next_nvSnap = nvSnap;
    if (pfSync && !pfPrev) begin
      next_nvCount = count; // [RULE12]
      next_nvSnap = snapVal; // [RULE12]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pfMeta <= 1'b0;
      pfSync <= 1'b0;
      pfPrev <= 1'b0;
      nvSave <= 1'b0;
      nvCount <= COUNT_ZERO;
      nvSnap <= COUNT_ZERO;
    end else if (ce) begin
      // The pin passes two flops before the edge detect reads it
      pfMeta <= powerFail;
      pfSync <= pfMeta;
      pfPrev <= pfSync;
      nvSave <= next_nvSave;
      nvCount <= next_nvCount;
      nvSnap <= next_nvSnap;
    end
  end

  // APB slave: one wait state, then pready with registered read data
  always_comb begin
    logic mapped;
    next_ctrlEnable = ctrlEnable;
    next_presetVal = presetVal;
    next_compareVal = compareVal;
    next_intMask = intMask;
    next_pready = psel & penable & ~pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    mapped = 1'b1;
    unique case (paddr)
      OFS_CTRL, OFS_PRESET, OFS_COMPARE, OFS_COUNT, OFS_SNAP,
      OFS_SNAP_TLO, OFS_SNAP_THI, OFS_STATE, OFS_INT_STAT,
      OFS_INT_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    if (psel && penable && !pready) begin
      next_pslverr = ~mapped;
      next_prdata = 32'h00000000;
      if (!pwrite) begin
        unique case (paddr)
          OFS_CTRL: next_prdata[CTRL_EN_BIT] = ctrlEnable;
          OFS_PRESET: next_prdata = presetVal;
          OFS_COMPARE: next_prdata = compareVal;
          OFS_COUNT: next_prdata = count;
          OFS_SNAP: next_prdata = snapVal;
          OFS_SNAP_TLO: next_prdata = snapTime[31:0];
          OFS_SNAP_THI: next_prdata = snapTime[63:32];
          OFS_STATE: begin
            next_prdata[STATE_BLOCK_BIT] = operands.block;
            next_prdata[STATE_PRESET_BIT] = operands.loadPresetSelect;
            next_prdata[STATE_EN_BIT] = enPrev;
            next_prdata[$bits(ucnt_flags_t)-1:0] = flags;
          end
          OFS_INT_STAT: next_prdata[INT_W-1:0] = intStat;
          OFS_INT_MASK: next_prdata[INT_W-1:0] = intMask;
          default: next_prdata = 32'h00000000;
        endcase
      end
    end
    if (apbWr) begin
      unique case (paddr)
        OFS_CTRL: next_ctrlEnable = pwdata[CTRL_EN_BIT];
        OFS_PRESET: next_presetVal = pwdata;
        OFS_COMPARE: next_compareVal = pwdata;
        OFS_INT_MASK: next_intMask = pwdata[INT_W-1:0];
        default: next_intMask = intMask;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlEnable <= 1'b0;
      presetVal <= PRESET_RST;
      compareVal <= COMPARE_RST;
      intMask <= INT_MASK_RST;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      ctrlEnable <= next_ctrlEnable;
      presetVal <= next_presetVal;
      compareVal <= next_compareVal;
      intMask <= next_intMask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Status bits: a new event outranks a write-one-to-clear in one cycle
  always_comb begin
    logic [INT_W-1:0] evts;
    evts = '0;
    evts[INT_SNAP_BIT] = snapEvt;
    evts[INT_WRAP_BIT] = wrapEvt;
    evts[INT_EQUAL_BIT] = equalEvt;
    next_intStat = (intStat & ~clrBits) | evts;
    next_irq = |(next_intStat & next_intMask);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      intStat <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      intStat <= next_intStat;
      irq <= next_irq;
    end
  end

endmodule
`default_nettype wire

// >>> ucnt_counter_properties.sv
// Port checker of the event counter, bound into every ucnt_counter.
// Assumes ce is held high by the surroundings.
`timescale 1ns/100ps
`default_nettype none
module ucnt_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ucnt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ucnt_pkg::ucnt_in_t operands,
  input wire logic powerFail,
  input wire ucnt_pkg::ucnt_flags_t flags,
  input wire logic nvSave,
  input wire logic [ucnt_pkg::COUNT_W-1:0] nvCount
);
  import ucnt_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence
  a_ready_time: assert property (s_setup_access |=> pready)
    else $error("pready late after access start");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_xfer: assert property (pready |-> psel && penable)
    else $error("pready outside a transfer");
  a_err_decode: assert property (pready && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > OFS_INT_MASK)) else $error("pslverr decode wrong");
  a_write_data: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  a_flags_exclusive: assert property ($onehot0(flags))
    else $error("more than one compare flag");
  a_block_flags: assert property (
    operands.block [*2] |-> flags == FLAGS_OFF)
    else $error("flags active while blocked");
  a_save_timing: assert property (
    $rose(powerFail) |-> ##[1:4] nvSave)
    else $error("no save pulse after power fail");
  a_save_hold: assert property (!nvSave |-> $stable(nvCount))
    else $error("saved count moved without save pulse");
endmodule
bind ucnt_counter ucnt_checker ucnt_checker_inst (.mclk(mclk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .operands(operands), .powerFail(powerFail), .flags(flags),
  .nvSave(nvSave), .nvCount(nvCount));
`default_nettype wire

// >>> ucnt_engine.sv
// Model of the logic engine: periodic pass strobe and operand levels.
// Assumes the bench sets want freely; operands move only after a pass.
`timescale 1ns/100ps
`default_nettype none
module ucnt_engine #(
  parameter int PASS_CYCLES = 6
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire ucnt_pkg::ucnt_in_t want,
  output logic passTick,
  output ucnt_pkg::ucnt_in_t operands
);
  import ucnt_pkg::*;
  logic [7:0] phase, next_phase;
  logic next_passTick;
  ucnt_in_t next_operands;
  always_comb begin
    next_passTick = phase == 8'(PASS_CYCLES - 1);
    next_phase = next_passTick ? 8'h00 : phase + 8'h01;
    // Levels change between passes, so each pass sees one stable level
    next_operands = passTick ? want : operands;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 8'h00;
      passTick <= 1'b0;
      operands <= '0;
    end else begin
      phase <= next_phase;
      passTick <= next_passTick;
      operands <= next_operands;
    end
  end
endmodule
`default_nettype wire

// >>> up_down_event_counter_tb.sv
// Bench of the event counter: APB tasks and operand steps via the engine.
// Assumes the engine model and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", n, e, a); end end
module up_down_event_counter_tb;
  import ucnt_pkg::*;
  localparam int UP_B = 6, DN_B = 5, RST_B = 2, SC_B = 1, SK_B = 0;
  logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic powerFail = 0, pready, pslverr, passTick, irq, nvSave, err;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [STAMP_W-1:0] dateTime = '0;
  logic [COUNT_W-1:0] nvCount, nvSnap;
  ucnt_in_t want = '0, operands;
  ucnt_flags_t flags;
  int bad_count = 0, n_compared = 0;
  initial forever #2.5 mclk = ~mclk;
  ucnt_engine ucnt_engine_inst (.mclk(mclk), .reset_n(reset_n), .want(want),
    .passTick(passTick), .operands(operands));
  ucnt_counter ucnt_counter_inst (.mclk(mclk), .reset_n(reset_n), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .passTick(passTick), .operands(operands), .dateTime(dateTime),
    .powerFail(powerFail), .flags(flags), .irq(irq), .nvSave(nvSave),
    .nvCount(nvCount), .nvSnap(nvSnap));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, q)
  endtask
  // Two passes: one to move the level, one for the counter to act on it
  task automatic go();
    repeat (2) do @(posedge mclk); while (passTick !== 1'b1);
    repeat (2) @(posedge mclk);
  endtask
  task automatic tog(input int b);
    want[b] <= 1'b1;
    go();
    want[b] <= 1'b0;
    go();
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd(8'(4 * i), 32'h0);
    rd(8'h40, 32'h0);
    `CHK("pslverr", 1'b1, err)
    apb(1'b1, OFS_PRESET, 32'h5);
    want.loadPresetSelect <= 1'b1;
    go();
    apb(1'b1, OFS_CTRL, 32'h1);
    go();
    rd(OFS_COUNT, 32'h5);
    want.up <= 1'b1;
    go();
    go();
    want.up <= 1'b0;
    go();
    rd(OFS_COUNT, 32'h6);
    want.loadPresetSelect <= 1'b0;
    go();
    tog(UP_B);
    rd(OFS_COUNT, 32'h7);
    want.loadPresetSelect <= 1'b1;
    go();
    rd(OFS_COUNT, 32'h5);
    tog(UP_B);
    tog(RST_B);
    rd(OFS_COUNT, 32'h5);
    want.loadPresetSelect <= 1'b0;
    go();
    tog(RST_B);
    rd(OFS_COUNT, 32'h0);
    `CHK("flags", 3'b010, flags)
    tog(DN_B);
    rd(OFS_COUNT, 32'hFFFFFFFF);
    `CHK("flags", 3'b001, flags)
    apb(1'b1, OFS_PRESET, COUNT_MAX);
    want.loadPresetSelect <= 1'b1;
    go();
    `CHK("flags", 3'b100, flags)
    tog(UP_B);
    rd(OFS_COUNT, COUNT_MIN);
    tog(DN_B);
    rd(OFS_COUNT, COUNT_MAX);
    want.block <= 1'b1;
    go();
    `CHK("flags", 3'b000, flags)
    tog(UP_B);
    rd(OFS_COUNT, COUNT_MAX);
    want.block <= 1'b0;
    go();
    // Wrap and equal events are pending here but still masked
    `CHK("irq", 1'b0, irq)
    apb(1'b1, OFS_INT_MASK, 32'h1);
    dateTime <= 64'h0123_4567_89AB_CDEF;
    tog(SK_B);
    rd(OFS_SNAP, COUNT_MAX);
    rd(OFS_COUNT, COUNT_MAX);
    rd(OFS_SNAP_TLO, 32'h89ABCDEF);
    rd(OFS_SNAP_THI, 32'h01234567);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, OFS_INT_STAT, 32'h7);
    `CHK("irq", 1'b0, irq)
    want.loadPresetSelect <= 1'b0;
    go();
    tog(UP_B);
    tog(SC_B);
    rd(OFS_SNAP, COUNT_MIN);
    rd(OFS_COUNT, 32'h0);
    // A non-zero count tells the capture apart from the reset value
    tog(UP_B);
    powerFail <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK("nvCount", 32'h1, nvCount)
    `CHK("nvSnap", COUNT_MIN, nvSnap)
    print_verdict();
  end
endmodule
`default_nettype wire
